// File: verilog/adcci_consts.svh
// adcci_consts.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the package and the design
`ifndef ADCCI_CONSTS_SVH
`define ADCCI_CONSTS_SVH
`define ADCCI_DW 14
`define ADCCI_ADDR_RESULT 2'h0
`define ADCCI_ADDR_GAIN 2'h1
`define ADCCI_ADDR_OFFSET 2'h2
`define ADCCI_ADDR_CTRL 2'h3
`define ADCCI_CTRL_RST 8'h00
`define ADCCI_GAIN_RST 3'h0
`define ADCCI_OFFS_RST 8'h00
`define ADCCI_BIT_PWD 13
`define ADCCI_BIT_REF 12
`define ADCCI_BIT_FMT 11
`define ADCCI_BIT_TMH 10
`define ADCCI_BIT_TML 8
`define ADCCI_BIT_OFF 7
`define ADCCI_BIT_SPARE 6
`define ADCCI_LAT_FULL 9
`define ADCCI_FIFO_DEPTH 8
`define ADCCI_MID_CODE 14'h2000
`endif

// File: verilog/adcci_pkg.sv
// adcci_pkg.sv: types shared by the converter control logic
// assumes adcci_consts.svh is on the include path
package adcci_pkg;
`include "adcci_consts.svh"
   typedef enum logic [2:0] {
      ADCCI_TM_NORMAL,
      ADCCI_TM_BOTH_LOW,
      ADCCI_TM_POS_HALF,
      ADCCI_TM_POS_UP_NEG_LOW,
      ADCCI_TM_BOTH_UP,
      ADCCI_TM_NEG_HALF,
      ADCCI_TM_POS_LOW_NEG_UP
   } adcci_route_t;
endpackage

// File: verilog/adcci_fifo.sv
// adcci_fifo.sv: small synchronous fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/100ps
module adcci_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0] cnt_ff;
   wire push = i_in_valid && o_in_ready;
   wire pop = o_out_valid && i_out_ready;
   assign o_in_ready = (cnt_ff != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_ff != '0);
   assign o_out_data = mem_ff[rd_ff];
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_ff[wr_ff] <= i_in_data;
      end
   end
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) wr_ff <= wr_ff + AW'(1);
         if (pop) rd_ff <= rd_ff + AW'(1);
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// File: verilog/adcci_top.sv
// adcci_top.sv: control registers, result correction, clip flag and bus drive
// assumes the analog core delivers a raw offset-binary code and an over-range level
// each sample clock, and the host bus is synchronous to i_clk
`timescale 1ns/100ps
`include "adcci_consts.svh"
module adcci_top
   import adcci_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_cs_n,
   input wire logic i_we_n,
   input wire logic i_output_enable_n,
   input wire logic [1:0] i_reg_select_lines,
   input wire logic [13:0] i_data,
   output logic [13:0] o_data,
   output logic o_data_oe,
   output logic o_clip_flag,
   input wire logic [13:0] i_raw_code,
   input wire logic i_raw_over,
   output logic o_power_down_bit,
   output logic o_bandgap_disconnect,
   output logic [2:0] o_gain_code,
   output adcci_route_t o_input_route,
   output logic o_fifo_overrun
);
   logic [7:0] ctrl_ff;
   logic [2:0] gain_ff;
   logic [7:0] offs_ff;
   logic [14:0] pipe_ff [`ADCCI_LAT_FULL];
   logic [14:0] fall_ff;
   logic [13:0] rd_ff;
   logic clip_ff;
   logic ovr_ff;
   wire wr_en = !i_cs_n && !i_we_n;
   wire rd_en = !i_cs_n && i_we_n;
   wire sel_gain = (i_reg_select_lines == `ADCCI_ADDR_GAIN);
   wire sel_offs = (i_reg_select_lines == `ADCCI_ADDR_OFFSET);
   wire sel_ctrl = (i_reg_select_lines == `ADCCI_ADDR_CTRL);
   wire sel_res = (i_reg_select_lines == `ADCCI_ADDR_RESULT);
   // control image: bits 13..6 stored, 5..0 always zero
   wire [13:0] ctrl_word = {ctrl_ff, 6'h00};
   wire fmt_twos = ctrl_ff[`ADCCI_BIT_FMT-6];
   wire corr_on = !ctrl_ff[`ADCCI_BIT_OFF-6];
   wire [2:0] tm = ctrl_ff[`ADCCI_BIT_TMH-6:`ADCCI_BIT_TML-6];
   // correction done in offset-binary, saturating to keep the code in range
   wire signed [15:0] offs_ext = 16'(signed'(offs_ff));
   wire signed [15:0] raw_ext = signed'({2'h0, i_raw_code});
   wire signed [15:0] diff = raw_ext - (corr_on ? offs_ext : 16'sh0000);
   wire [13:0] corr_code = diff < 16'sh0000 ? 14'h0000 :
      (diff > 16'sh3fff ? 14'h3fff : diff[13:0]);
   wire [13:0] fmt_code = fmt_twos ? (corr_code ^ `ADCCI_MID_CODE) : corr_code;
   logic [14:0] fifo_q;
   logic fifo_valid;
   logic fifo_in_ready;
   assign o_power_down_bit = ctrl_ff[`ADCCI_BIT_PWD-6];
   assign o_bandgap_disconnect = ctrl_ff[`ADCCI_BIT_REF-6];
   assign o_gain_code = gain_ff;
   // test routings 000 and 100 both give normal input
   assign o_input_route = (tm == 3'h1) ? ADCCI_TM_BOTH_LOW :
      (tm == 3'h2) ? ADCCI_TM_POS_HALF :
      (tm == 3'h3) ? ADCCI_TM_POS_UP_NEG_LOW :
      (tm == 3'h5) ? ADCCI_TM_BOTH_UP :
      (tm == 3'h6) ? ADCCI_TM_NEG_HALF :
      (tm == 3'h7) ? ADCCI_TM_POS_LOW_NEG_UP : ADCCI_TM_NORMAL;
   assign o_data_oe = !i_output_enable_n;
   assign o_data = rd_ff;
   assign o_clip_flag = clip_ff;
   assign o_fifo_overrun = ovr_ff;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_ff <= `ADCCI_CTRL_RST;
         gain_ff <= `ADCCI_GAIN_RST;
         offs_ff <= `ADCCI_OFFS_RST;
      end else if (wr_en) begin
         if (sel_ctrl) ctrl_ff <= i_data[13:6];
         if (sel_gain) gain_ff <= i_data[2:0];
         if (sel_offs) offs_ff <= i_data[7:0];
      end
   end
   // nine full stages on the rising edge plus a falling-edge half stage
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int k = 0; k < `ADCCI_LAT_FULL; k++) pipe_ff[k] <= '0;
      end else begin
         pipe_ff[0] <= {i_raw_over, fmt_code};
         for (int k = 1; k < `ADCCI_LAT_FULL; k++) pipe_ff[k] <= pipe_ff[k-1];
      end
   end
   always_ff @(negedge i_clk or negedge i_rstn) begin
      if (!i_rstn) fall_ff <= '0;
      else fall_ff <= pipe_ff[`ADCCI_LAT_FULL-1];
   end
   // fifo drains only while result slot is being read; overrun is reported
   wire fifo_pop = rd_en && sel_res && !i_output_enable_n;
   adcci_fifo #(.WIDTH(15), .DEPTH(`ADCCI_FIFO_DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_in_valid(1'b1),
      .o_in_ready(fifo_in_ready),
      .i_in_data(fall_ff),
      .o_out_valid(fifo_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_q)
   );
   wire [13:0] res_word = fifo_valid ? fifo_q[13:0] : fall_ff[13:0];
   wire res_clip = fifo_valid ? fifo_q[14] : fall_ff[14];
   wire [13:0] rd_mux = sel_ctrl ? ctrl_word :
      sel_offs ? {6'h00, offs_ff} :
      sel_gain ? {11'h000, gain_ff} : res_word;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rd_ff <= '0;
         clip_ff <= 1'b0;
         ovr_ff <= 1'b0;
      end else begin
         rd_ff <= rd_mux;
         if (sel_res) clip_ff <= res_clip;
         ovr_ff <= !fifo_in_ready;
      end
   end
   property p_ctrl_read;
      @(posedge i_clk) disable iff (!i_rstn)
      sel_ctrl |=> (o_data == $past(ctrl_word) && o_data[5:0] == 6'h00);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
   property p_ctrl_write;
      @(posedge i_clk) disable iff (!i_rstn)
      (wr_en && sel_ctrl) |=> (ctrl_ff == $past(i_data[13:6]));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
   property p_pwd;
      @(posedge i_clk) disable iff (!i_rstn)
      (wr_en && sel_ctrl) |=> (o_power_down_bit == $past(i_data[13]));
   endproperty
   a_pwd: assert property (p_pwd) else $error("power down bit wrong");
   property p_ref;
      @(posedge i_clk) disable iff (!i_rstn)
      (wr_en && sel_ctrl) |=> (o_bandgap_disconnect == $past(i_data[12]));
   endproperty
   a_ref: assert property (p_ref) else $error("reference select wrong");
   property p_gain;
      @(posedge i_clk) disable iff (!i_rstn)
      (wr_en && sel_gain) |=> (o_gain_code == $past(i_data[2:0]));
   endproperty
   a_gain: assert property (p_gain) else $error("gain code wrong");
   property p_oe;
      @(posedge i_clk) disable iff (!i_rstn)
      o_data_oe == !i_output_enable_n;
   endproperty
   a_oe: assert property (p_oe) else $error("drive outside enable");
   property p_corr_off;
      @(posedge i_clk) disable iff (!i_rstn)
      (!corr_on && !fmt_twos) |-> (fmt_code == i_raw_code);
   endproperty
   a_corr_off: assert property (p_corr_off) else $error("correction not bypassed");
   property p_latency;
      @(posedge i_clk) disable iff (!i_rstn)
      ##0 1'b1 |-> ##9 (pipe_ff[8][14] == $past(i_raw_over, 9));
   endproperty
   a_latency: assert property (p_latency) else $error("clip delay mismatch");
   property p_route;
      @(posedge i_clk) disable iff (!i_rstn)
      (tm == 3'h4) |-> (o_input_route == ADCCI_TM_NORMAL);
   endproperty
   a_route: assert property (p_route) else $error("test route wrong");
   property p_route_0;
      @(posedge i_clk) disable iff (!i_rstn)
      (tm == 3'h0) |-> (o_input_route == ADCCI_TM_NORMAL);
   endproperty
   a_route_0: assert property (p_route_0) else $error("route 0 wrong");
   property p_route_1;
      @(posedge i_clk) disable iff (!i_rstn)
      (tm == 3'h1) |-> (o_input_route == ADCCI_TM_BOTH_LOW);
   endproperty
   a_route_1: assert property (p_route_1) else $error("route 1 wrong");
   property p_route_2;
      @(posedge i_clk) disable iff (!i_rstn)
      (tm == 3'h2) |-> (o_input_route == ADCCI_TM_POS_HALF);
   endproperty
   a_route_2: assert property (p_route_2) else $error("route 2 wrong");
   property p_route_3;
      @(posedge i_clk) disable iff (!i_rstn)
      (tm == 3'h3) |-> (o_input_route == ADCCI_TM_POS_UP_NEG_LOW);
   endproperty
   a_route_3: assert property (p_route_3) else $error("route 3 wrong");
   property p_route_5;
      @(posedge i_clk) disable iff (!i_rstn)
      (tm == 3'h5) |-> (o_input_route == ADCCI_TM_BOTH_UP);
   endproperty
   a_route_5: assert property (p_route_5) else $error("route 5 wrong");
   property p_route_6;
      @(posedge i_clk) disable iff (!i_rstn)
      (tm == 3'h6) |-> (o_input_route == ADCCI_TM_NEG_HALF);
   endproperty
   a_route_6: assert property (p_route_6) else $error("route 6 wrong");
   property p_route_7;
      @(posedge i_clk) disable iff (!i_rstn)
      (tm == 3'h7) |-> (o_input_route == ADCCI_TM_POS_LOW_NEG_UP);
   endproperty
   a_route_7: assert property (p_route_7) else $error("route 7 wrong");

   property p_fmt_twos;
      @(posedge i_clk) disable iff (!i_rstn)
      (!corr_on && fmt_twos) |-> (fmt_code == (i_raw_code ^ `ADCCI_MID_CODE));
   endproperty
   a_fmt_twos: assert property (p_fmt_twos) else $error("two's complement wrong");
   property p_corr_zero;
      @(posedge i_clk) disable iff (!i_rstn)
      (corr_on && !fmt_twos && offs_ff == 8'h00) |-> (fmt_code == i_raw_code);
   endproperty
   a_corr_zero: assert property (p_corr_zero) else $error("zero offset altered");
   // inside this code window the subtraction cannot saturate
   property p_corr_sub;
      @(posedge i_clk) disable iff (!i_rstn)
      (corr_on && !fmt_twos && i_raw_code >= 14'h0080 && i_raw_code <= 14'h3f7f) |->
         (fmt_code == i_raw_code - {{6{offs_ff[7]}}, offs_ff});
   endproperty
   a_corr_sub: assert property (p_corr_sub) else $error("offset not subtracted");
   property p_gain_rd;
      @(posedge i_clk) disable iff (!i_rstn)
      sel_gain |=> (o_data == {11'h000, $past(gain_ff)});
   endproperty
   a_gain_rd: assert property (p_gain_rd) else $error("gain readback wrong");
   property p_offs_rd;
      @(posedge i_clk) disable iff (!i_rstn)
      sel_offs |=> (o_data == {6'h00, $past(offs_ff)});
   endproperty
   a_offs_rd: assert property (p_offs_rd) else $error("offset readback wrong");
   property p_offs_wr;
      @(posedge i_clk) disable iff (!i_rstn)
      (wr_en && sel_offs) |=> (offs_ff == $past(i_data[7:0]));
   endproperty
   a_offs_wr: assert property (p_offs_wr) else $error("offset write lost");
   property p_spare;
      @(posedge i_clk) disable iff (!i_rstn)
      (wr_en && sel_ctrl) |=> (ctrl_word[`ADCCI_BIT_SPARE] == $past(i_data[6]));
   endproperty
   a_spare: assert property (p_spare) else $error("spare bit position wrong");
   property p_res_wr_ign;
      @(posedge i_clk) disable iff (!i_rstn)
      (wr_en && sel_res) |=> ($stable(ctrl_ff) && $stable(gain_ff) && $stable(offs_ff));
   endproperty
   a_res_wr_ign: assert property (p_res_wr_ign) else $error("result write not ignored");
   property p_fmt_wr;
      @(posedge i_clk) disable iff (!i_rstn)
      (wr_en && sel_ctrl) |=> (fmt_twos == $past(i_data[11]));
   endproperty
   a_fmt_wr: assert property (p_fmt_wr) else $error("format bit wrong");
   property p_off_wr;
      @(posedge i_clk) disable iff (!i_rstn)
      (wr_en && sel_ctrl) |=> (corr_on == !$past(i_data[7]));
   endproperty
   a_off_wr: assert property (p_off_wr) else $error("correction enable wrong");
   property p_half_stage;
      @(posedge i_clk) disable iff (!i_rstn)
      fall_ff == pipe_ff[`ADCCI_LAT_FULL-1];
   endproperty
   a_half_stage: assert property (p_half_stage) else $error("half stage lost");
   property p_clip_reg;
      @(posedge i_clk) disable iff (!i_rstn)
      sel_res |=> (o_clip_flag == $past(res_clip));
   endproperty
   a_clip_reg: assert property (p_clip_reg) else $error("clip flag not updated");
   property p_clip_hold;
      @(posedge i_clk) disable iff (!i_rstn)
      !sel_res |=> $stable(o_clip_flag);
   endproperty
   a_clip_hold: assert property (p_clip_hold) else $error("clip flag moved");
   property p_res_live;
      @(posedge i_clk) disable iff (!i_rstn)
      (sel_res && !fifo_valid) |=> (o_data == $past(fall_ff[13:0]));
   endproperty
   a_res_live: assert property (p_res_live) else $error("live result wrong");

   // write then read back on the next cycle
   sequence s_ctrl_wr;
      wr_en && sel_ctrl;
   endsequence
   sequence s_ctrl_rd;
      sel_ctrl && !wr_en;
   endsequence
   sequence s_gain_wr;
      wr_en && sel_gain;
   endsequence
   sequence s_gain_rd;
      sel_gain && !wr_en;
   endsequence
   property p_ctrl_round;
      @(posedge i_clk) disable iff (!i_rstn)
      s_ctrl_wr ##1 s_ctrl_rd |=> (o_data[13:6] == $past(i_data[13:6], 2));
   endproperty
   a_ctrl_round: assert property (p_ctrl_round) else $error("control round trip wrong");
   property p_gain_round;
      @(posedge i_clk) disable iff (!i_rstn)
      s_gain_wr ##1 s_gain_rd |=> (o_data[2:0] == $past(i_data[2:0], 2));
   endproperty
   a_gain_round: assert property (p_gain_round) else $error("gain round trip wrong");
endmodule

// File: tb/adcci_core_model.sv
// adcci_core_model.sv: behavioural stand-in for the analog core
// assumes the bench sets the level to convert and the over-range state
`timescale 1ns/100ps
module adcci_core_model (
   input wire logic i_clk,
   input wire logic [13:0] i_level,
   input wire logic i_over_level,
   input wire logic i_power_down_bit,
   output logic [13:0] o_raw_code,
   output logic o_raw_over
);
   initial o_raw_code = 14'h2000;
   initial o_raw_over = 1'b0;
   // powered down: no valid code, so show a toggling pattern
   always @(posedge i_clk) begin
      o_raw_code <= i_power_down_bit ? ~o_raw_code : i_level;
      o_raw_over <= i_over_level;
   end
endmodule

// File: tb/adc_control_interface_bench.sv
// adc_control_interface_bench.sv: self-checking bench of adcci_top
// assumes the core model above and a host bus synchronous to i_clk
`timescale 1ns/100ps
module adc_control_interface_bench;
   import adcci_pkg::*;
   logic i_clk = 0, i_rstn = 0, cs_n = 1, we_n = 1, oe_n = 1, over = 0;
   logic [1:0] sel = 0;
   logic [13:0] wd = 0, lvl = 14'h2000, o_data, raw, d;
   logic oe, clip, pd, bgd, ovr, rov;
   logic [2:0] gc;
   logic [7:0] off;
   adcci_route_t rt;
   int mismatches = 0, compares = 0, n;
   logic [31:0] seed = 32'h5399;
   always #12.5 i_clk = ~i_clk;
   adcci_top dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_cs_n(cs_n), .i_we_n(we_n),
      .i_output_enable_n(oe_n), .i_reg_select_lines(sel), .i_data(wd), .o_data(o_data),
      .o_data_oe(oe), .o_clip_flag(clip), .i_raw_code(raw), .i_raw_over(rov),
      .o_power_down_bit(pd), .o_bandgap_disconnect(bgd), .o_gain_code(gc),
      .o_input_route(rt), .o_fifo_overrun(ovr));
   adcci_core_model u_core (.i_clk(i_clk), .i_level(lvl), .i_over_level(over),
      .i_power_down_bit(pd), .o_raw_code(raw), .o_raw_over(rov));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic adcci_route_t route_exp(input logic [2:0] t);
      case (t)
         3'h1: return ADCCI_TM_BOTH_LOW;
         3'h2: return ADCCI_TM_POS_HALF;
         3'h3: return ADCCI_TM_POS_UP_NEG_LOW;
         3'h5: return ADCCI_TM_BOTH_UP;
         3'h6: return ADCCI_TM_NEG_HALF;
         3'h7: return ADCCI_TM_POS_LOW_NEG_UP;
         default: return ADCCI_TM_NORMAL;
      endcase
   endfunction
   // correction on the offset-binary code, clamped to the code range
   function automatic logic [13:0] res_exp(input logic [13:0] r, input logic [7:0] o,
         input logic dis, input logic fmt);
      int v;
      v = int'(r);
      if (!dis) v = v - int'($signed(o));
      if (v < 0) v = 0;
      if (v > 16383) v = 16383;
      return v[13:0] ^ {fmt, 13'h0};
   endfunction
   task automatic chk(input string nm, input logic [13:0] s, input logic [13:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic print_verdict();
      $display("counts: compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [1:0] s, input logic [13:0] v);
      @(posedge i_clk);
      cs_n <= 0;
      we_n <= 0;
      sel <= s;
      wd <= v;
      @(posedge i_clk);
      we_n <= 1;
   endtask
   task automatic rd(input logic [1:0] s, input logic [13:0] e, input string nm);
      @(posedge i_clk);
      sel <= s;
      oe_n <= 0;
      repeat (2) @(posedge i_clk);
      #1 chk(nm, o_data, e);
   endtask
   initial begin
      repeat (10) @(posedge i_clk);
      i_rstn <= 1;
      rd(2'h1, 14'h0, "gain reset");
      rd(2'h2, 14'h0, "offset reset");
      rd(2'h3, 14'h0, "ctrl reset");
      for (int i = 0; i < 8; i++) begin
         d = 14'(rnd());
         d[10:8] = 3'(i);
         d[6] = 1'b0;
         wr(2'h3, d);
         rd(2'h3, d & 14'h3f80, "ctrl readback");
         chk("power down", 14'(pd), 14'(d[13]));
         chk("bandgap", 14'(bgd), 14'(d[12]));
         chk("route", 14'(rt), 14'(route_exp(d[10:8])));
      end
      $display("test control done");
      for (int g = 0; g < 8; g++) begin
         wr(2'h1, 14'(g));
         rd(2'h1, 14'(g), "gain readback");
         chk("gain code", 14'(gc), 14'(g));
      end
      wr(2'h0, 14'h1555);
      rd(2'h1, 14'h7, "gain after result write");
      $display("test gain done");
      for (int k = 0; k < 6; k++) begin
         lvl <= (k == 4) ? 14'h5 : (k == 5) ? 14'h3ffe : 14'(rnd());
         off = (k == 4) ? 8'h7f : (k == 5) ? 8'h80 : 8'(rnd());
         over <= k[0];
         wr(2'h2, {6'h0, off});
         rd(2'h2, {6'h0, off}, "offset readback");
         wr(2'h3, {2'h0, k[1], 3'h0, k[0] && k < 4, 7'h0});
         @(posedge i_clk);
         sel <= 2'h0;
         repeat (30) @(posedge i_clk);
         #1 chk("result", o_data, res_exp(lvl, off, k[0] && k < 4, k[1]));
         chk("clip", 14'(clip), 14'(k[0]));
         chk("drive on", 14'(oe), 14'h1);
      end
      $display("test result done");
      wr(2'h2, 14'h0);
      wr(2'h3, 14'h0800);
      lvl <= 14'h2005;
      @(posedge i_clk);
      sel <= 2'h0;
      repeat (30) @(posedge i_clk);
      #1 chk("zero input", o_data, 14'h0005);
      d = o_data;
      wr(2'h2, {6'h0, d[7:0]});
      @(posedge i_clk);
      sel <= 2'h0;
      repeat (30) @(posedge i_clk);
      #1 chk("calibrated", o_data, 14'h0000);
      $display("test calibration done");
      @(posedge i_clk);
      oe_n <= 1;
      sel <= 2'h1;
      #1 chk("drive off", 14'(oe), 14'h0);
      for (n = 0; n < 40 && ovr !== 1'b1; n++) @(posedge i_clk);
      chk("fifo full", 14'(ovr), 14'h1);
      if (n == 40) print_verdict();
      sel <= 2'h0;
      oe_n <= 0;
      for (n = 0; n < 40 && ovr !== 1'b0; n++) @(posedge i_clk);
      chk("fifo drained", 14'(ovr), 14'h0);
      $display("test fifo done");
      print_verdict();
   end
endmodule
